// ===== common/hpc_pkg.sv
// constants, types and register map of the hiccup and phase configuration block
package hpc_pkg;
    // wishbone register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [15:0] PERIOD_RST = 16'h0190;
    // status and count field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_VALID = 4;
    localparam int ST_SECONDARY = 5;
    localparam int ST_SPREAD = 6;
    localparam int ST_DUAL = 7;
    localparam int ST_LOCKED = 8;
    localparam int ST_PFM = 9;
    localparam int ST_HS = 10;
    localparam int ST_LS = 11;
    localparam int CNT_OVL_LSB = 0;
    localparam int CNT_OFF_LSB = 16;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int DEAD_NS = 20;
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int SOFTSTART_MS = 3;
    localparam int SOFTSTART_CYC = SOFTSTART_MS * CLK_MHZ * 1000;
    localparam int OVL_CYCLES = 512;
    localparam int OFF_CYCLES = 16384;
    localparam int CLEAN_CYCLES = 4;
    localparam int LOCK_EDGES = 2;
    // strap codes from the strap resistor comparator ladder
    localparam logic [2:0] STRAP_29K9 = 3'h0;
    localparam logic [2:0] STRAP_41K2 = 3'h1;
    localparam logic [2:0] STRAP_54K9 = 3'h2;
    localparam logic [2:0] STRAP_71K5 = 3'h3;
    localparam logic [2:0] STRAP_90K9 = 3'h4;
    typedef enum logic [1:0] {HIC_DISABLED, HIC_SOFTSTART, HIC_RUN, HIC_OFF} hpc_hic_t;
    typedef enum logic [2:0] {
        GATE_IDLE, GATE_HI_WAIT, GATE_HI, GATE_LO_WAIT, GATE_LO_DLY, GATE_LO
    } hpc_gate_t;
endpackage

// ===== common/hpc_cnt_if.sv
// counter control and result bundle
interface hpc_cnt_if #(parameter int WIDTH = 8);
    logic clr;
    logic inc;
    logic [WIDTH-1:0] count;
    logic done;
    modport counter(input clr, input inc, output count, output done);
    modport user(output clr, output inc, input count, input done);
endinterface

// ===== logic/hpc_counter.sv
// saturating event counter with clear, done at LAST
module hpc_counter
    import hpc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int LAST = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control and result
    hpc_cnt_if.counter cnt
);
    // clear wins, then count up and hold at LAST
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt.count <= '0;
        end else if (cnt.clr) begin
            cnt.count <= '0;
        end else if (cnt.inc && !cnt.done) begin
            cnt.count <= cnt.count + WIDTH'(1);
        end
    end

    assign cnt.done = (cnt.count == WIDTH'(LAST));
endmodule

// ===== logic/hpc_top.sv
// hiccup protection, dead-time interlock, strap latch and phase sync
module hpc_top
    import hpc_pkg::*;
#(
    parameter int SS_CYCLES = SOFTSTART_CYC
) (
    // clock and bias undervoltage reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // analog comparators and pins
    input wire logic BIAS_ABOVE_3V3,
    input wire logic [2:0] CONFIG_STRAP_PIN,
    input wire logic CURRENT_LIMIT_TRIP,
    input wire logic PWM_END,
    input wire logic FEEDBACK_SENSE_ABOVE_0V4,
    input wire logic HIGH_SIDE_GATE_BELOW_2V,
    input wire logic LOW_SIDE_GATE_BELOW_2V,
    input wire logic ENABLE_PIN,
    input wire logic LIGHT_LOAD_OR_SYNC_INPUT,
    input wire logic PULSE_SKIP,
    // gate drives and sync
    output logic HIGH_SIDE_GATE_DRIVE,
    output logic LOW_SIDE_GATE_DRIVE,
    output logic POWER_GOOD_OR_SYNC_OUTPUT,
    // analog controls
    output logic SOFT_START_HOLD_LOW,
    output logic SOFT_START_ACTIVE,
    output logic ERROR_AMP_ENABLE,
    output logic COMPENSATION_NODE_OE,
    output logic INTERNAL_COMP_ALLOWED,
    output logic FREQUENCY_SET_RESISTOR_SLOPE,
    output logic SPREAD_ACTIVE
);
    localparam int NSYNC = 12;

    logic [NSYNC-1:0] meta_reg;
    logic [NSYNC-1:0] sync_reg;
    logic bias_s, cl_s, pwm_end_s, fb_s, ho_low_s, lo_low_s, en_s, syn_s, skip_s;
    logic [2:0] strap_s;
    logic syn_d_reg;
    logic sync_rise;
    logic [15:0] period_reg;
    logic [16:0] period_eff;
    logic [16:0] phase_reg;
    logic [17:0] gap_reg;
    logic [7:0] lfsr_reg;
    logic [1:0] edges_reg;
    logic locked_reg;
    logic osc_tick, sw_tick, allow_ext, ext_present, pfm_mode;
    logic cfg_valid_reg, cfg_secondary_reg, cfg_spread_reg, cfg_dual_reg;
    hpc_hic_t state_reg, state_next;
    hpc_gate_t gate_reg, gate_next;
    logic [2:0] dt_cnt_reg;
    logic trip_reg;
    logic armed, switching_on, hs_start, hs_end;
    logic pg_next;
    logic wb_req;
    logic [31:0] rd_data;

    hpc_cnt_if #(.WIDTH(10)) ovl_c();
    hpc_cnt_if #(.WIDTH(3)) clean_c();
    hpc_cnt_if #(.WIDTH(15)) off_c();
    hpc_cnt_if #(.WIDTH(20)) ss_c();

    // two-flop synchronisers for every pin and comparator input
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {BIAS_ABOVE_3V3, CONFIG_STRAP_PIN, CURRENT_LIMIT_TRIP, PWM_END,
                FEEDBACK_SENSE_ABOVE_0V4, HIGH_SIDE_GATE_BELOW_2V, LOW_SIDE_GATE_BELOW_2V,
                ENABLE_PIN, LIGHT_LOAD_OR_SYNC_INPUT, PULSE_SKIP};
            sync_reg <= meta_reg;
        end
    end

    assign {bias_s, strap_s, cl_s, pwm_end_s, fb_s, ho_low_s, lo_low_s, en_s, syn_s,
        skip_s} = sync_reg;

    // strap latch: sampled once bias is good, dropped when bias falls
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_valid_reg <= 1'b0;
            cfg_secondary_reg <= 1'b0;
            cfg_spread_reg <= 1'b0;
            cfg_dual_reg <= 1'b0;
        end else if (!bias_s) begin
            cfg_valid_reg <= 1'b0;
            cfg_secondary_reg <= 1'b0;
            cfg_spread_reg <= 1'b0;
            cfg_dual_reg <= 1'b0;
        end else if (!cfg_valid_reg) begin
            cfg_valid_reg <= 1'b1;
            cfg_secondary_reg <= (strap_s == STRAP_90K9);
            cfg_spread_reg <= (strap_s == STRAP_41K2) || (strap_s == STRAP_71K5);
            cfg_dual_reg <= (strap_s == STRAP_54K9) || (strap_s == STRAP_71K5)
                || (strap_s == STRAP_90K9);
        end
    end

    // oscillator with optional pseudo-random period dither
    assign period_eff = {1'b0, period_reg}
        + (SPREAD_ACTIVE ? {13'h0000, lfsr_reg[3:0]} : 17'h00000);
    assign osc_tick = (phase_reg >= period_eff - 17'h00001);
    assign sync_rise = syn_s && !syn_d_reg;
    assign allow_ext = cfg_valid_reg && !cfg_secondary_reg && !cfg_spread_reg;
    assign ext_present = (edges_reg != 2'h0) || locked_reg;
    assign pfm_mode = !cfg_secondary_reg && !ext_present && syn_s;
    assign sw_tick = (cfg_secondary_reg || locked_reg) ? sync_rise : osc_tick;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_reg <= '0;
            lfsr_reg <= 8'h01;
            syn_d_reg <= 1'b0;
        end else begin
            syn_d_reg <= syn_s;
            phase_reg <= sw_tick ? 17'h00000 : phase_reg + 17'h00001;
            if (sw_tick) begin
                lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
            end
        end
    end

    // external clock detection; lock on the third rising edge, drop after over two periods with no edge
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            edges_reg <= '0;
            locked_reg <= 1'b0;
            gap_reg <= '0;
        end else if (!allow_ext || gap_reg > {period_eff, 1'b0}) begin
            edges_reg <= '0;
            locked_reg <= 1'b0;
            gap_reg <= '0;
        end else if (sync_rise) begin
            gap_reg <= '0;
            if (edges_reg == 2'(LOCK_EDGES)) begin
                locked_reg <= 1'b1;
            end else begin
                edges_reg <= edges_reg + 2'h1;
            end
        end else if (ext_present) begin
            gap_reg <= gap_reg + 18'h00001;
        end
    end

    // overload flag for the current switching cycle, a trip at the tick is kept
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            trip_reg <= 1'b0;
        end else if (sw_tick) begin
            trip_reg <= cl_s;
        end else if (cl_s) begin
            trip_reg <= 1'b1;
        end
    end

    // hiccup sequence counters
    assign armed = (state_reg == HIC_RUN) || (state_reg == HIC_SOFTSTART && fb_s);
    assign ovl_c.clr = !armed || clean_c.done;
    assign ovl_c.inc = sw_tick && trip_reg;
    assign clean_c.clr = !armed || clean_c.done || (sw_tick && trip_reg);
    assign clean_c.inc = sw_tick && !trip_reg;
    assign off_c.clr = (state_reg != HIC_OFF);
    assign off_c.inc = sw_tick;
    assign ss_c.clr = (state_reg != HIC_SOFTSTART);
    assign ss_c.inc = 1'b1;

    hpc_counter #(.WIDTH(10), .LAST(OVL_CYCLES)) u_ovl (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .cnt(ovl_c.counter)
    );
    hpc_counter #(.WIDTH(3), .LAST(CLEAN_CYCLES)) u_clean (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .cnt(clean_c.counter)
    );
    hpc_counter #(.WIDTH(15), .LAST(OFF_CYCLES)) u_off (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .cnt(off_c.counter)
    );
    hpc_counter #(.WIDTH(20), .LAST(SS_CYCLES)) u_ss (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .cnt(ss_c.counter)
    );

    // hiccup state machine
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            HIC_DISABLED: if (cfg_valid_reg && en_s) state_next = HIC_SOFTSTART;
            HIC_SOFTSTART: begin
                if (ovl_c.done) begin
                    state_next = HIC_OFF;
                end else if (ss_c.done) begin
                    state_next = HIC_RUN;
                end
            end
            HIC_RUN: if (ovl_c.done) state_next = HIC_OFF;
            HIC_OFF: if (off_c.done) state_next = HIC_SOFTSTART;
        endcase
        if (!en_s || !cfg_valid_reg) begin
            state_next = HIC_DISABLED;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= HIC_DISABLED;
        end else begin
            state_reg <= state_next;
        end
    end

    // adaptive dead-time gate sequencer
    assign switching_on = (state_reg == HIC_SOFTSTART) || (state_reg == HIC_RUN);
    assign hs_start = sw_tick && switching_on && !(pfm_mode && skip_s);
    assign hs_end = pwm_end_s || cl_s || !switching_on;

    always_comb begin
        gate_next = gate_reg;
        unique case (gate_reg)
            GATE_IDLE: if (hs_start) gate_next = GATE_HI_WAIT;
            GATE_HI_WAIT: begin
                if (!switching_on) begin
                    gate_next = GATE_IDLE;
                end else if (lo_low_s) begin
                    gate_next = GATE_HI;
                end
            end
            GATE_HI: if (hs_end) gate_next = GATE_LO_WAIT;
            GATE_LO_WAIT: if (ho_low_s) gate_next = GATE_LO_DLY;
            GATE_LO_DLY: begin
                if (!switching_on) begin
                    gate_next = GATE_IDLE;
                end else if (dt_cnt_reg == 3'(DEAD_CYC - 1)) begin
                    gate_next = GATE_LO;
                end
            end
            GATE_LO: begin
                if (!switching_on) begin
                    gate_next = GATE_IDLE;
                end else if (hs_start) begin
                    gate_next = GATE_HI_WAIT;
                end
            end
            default: gate_next = GATE_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gate_reg <= GATE_IDLE;
            dt_cnt_reg <= '0;
            HIGH_SIDE_GATE_DRIVE <= 1'b0;
            LOW_SIDE_GATE_DRIVE <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            dt_cnt_reg <= (gate_reg == GATE_LO_DLY) ? dt_cnt_reg + 3'h1 : 3'h0;
            HIGH_SIDE_GATE_DRIVE <= (gate_next == GATE_HI);
            LOW_SIDE_GATE_DRIVE <= (gate_next == GATE_LO);
        end
    end

    // power-good or interleave sync output and analog controls
    always_comb begin
        if (!cfg_secondary_reg && cfg_dual_reg) begin
            pg_next = !(pfm_mode && skip_s) && (phase_reg >= (period_eff >> 1));
        end else begin
            pg_next = (state_reg == HIC_RUN);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            POWER_GOOD_OR_SYNC_OUTPUT <= 1'b0;
            SOFT_START_HOLD_LOW <= 1'b1;
            SOFT_START_ACTIVE <= 1'b0;
            ERROR_AMP_ENABLE <= 1'b0;
            COMPENSATION_NODE_OE <= 1'b0;
            INTERNAL_COMP_ALLOWED <= 1'b0;
            FREQUENCY_SET_RESISTOR_SLOPE <= 1'b0;
            SPREAD_ACTIVE <= 1'b0;
        end else begin
            POWER_GOOD_OR_SYNC_OUTPUT <= pg_next;
            SOFT_START_HOLD_LOW <= (state_next inside {HIC_OFF, HIC_DISABLED});
            SOFT_START_ACTIVE <= (state_next == HIC_SOFTSTART);
            ERROR_AMP_ENABLE <= cfg_valid_reg && !cfg_secondary_reg;
            COMPENSATION_NODE_OE <= cfg_valid_reg && !cfg_secondary_reg;
            INTERNAL_COMP_ALLOWED <= cfg_valid_reg && !cfg_dual_reg;
            FREQUENCY_SET_RESISTOR_SLOPE <= cfg_secondary_reg;
            SPREAD_ACTIVE <= cfg_spread_reg && !cfg_secondary_reg;
        end
    end

    // wishbone slave: one wait state, ack for one cycle
    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

    always_comb begin
        rd_data = 32'h00000000;
        unique case (WB_ADR_I)
            REG_CTRL: rd_data[15:0] = period_reg;
            REG_STATUS: begin
                rd_data[ST_STATE_LSB +: 2] = state_reg;
                rd_data[ST_VALID] = cfg_valid_reg;
                rd_data[ST_SECONDARY] = cfg_secondary_reg;
                rd_data[ST_SPREAD] = cfg_spread_reg;
                rd_data[ST_DUAL] = cfg_dual_reg;
                rd_data[ST_LOCKED] = locked_reg;
                rd_data[ST_PFM] = pfm_mode;
                rd_data[ST_HS] = HIGH_SIDE_GATE_DRIVE;
                rd_data[ST_LS] = LOW_SIDE_GATE_DRIVE;
            end
            REG_COUNT: begin
                rd_data[CNT_OVL_LSB +: 10] = ovl_c.count;
                rd_data[CNT_OFF_LSB +: 15] = off_c.count;
            end
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= wb_req;
            if (wb_req && !WB_WE_I) begin
                WB_DAT_O <= rd_data;
            end
        end
    end

    // period register, byte lanes 0 and 1
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            period_reg <= PERIOD_RST;
        end else if (wb_req && WB_WE_I && WB_ADR_I == REG_CTRL) begin
            if (WB_SEL_I[0]) period_reg[7:0] <= WB_DAT_I[7:0];
            if (WB_SEL_I[1]) period_reg[15:8] <= WB_DAT_I[15:8];
        end
    end
endmodule

// ===== tb/hpc_fet_model.sv
// behavioural power stage: gate voltages and the pwm comparator
module hpc_fet_model (
    // clock and speed select
    input wire logic clk,
    input wire logic slow,
    // gate drives from the controller
    input wire logic hs_drive,
    input wire logic ls_drive,
    // comparator outputs back to the controller
    output logic hs_below_2v = 1'b1,
    output logic ls_below_2v = 1'b1,
    output logic pwm_end = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int hs_off = 8;
    int ls_off = 8;
    int hs_on = 0;
    // a gate discharges in one cycle, or in six when slow
    always @(posedge clk) begin
        hs_off <= hs_drive ? 0 : hs_off + 1;
        ls_off <= ls_drive ? 0 : ls_off + 1;
        hs_on <= hs_drive ? hs_on + 1 : 0;
        hs_below_2v <= !hs_drive && hs_off >= (slow ? 6 : 1);
        ls_below_2v <= !ls_drive && ls_off >= (slow ? 6 : 1);
        pwm_end <= hs_drive && hs_on >= 3; // ends the pulse after a short on time
    end
endmodule

// ===== tb/hpc_top_properties.sv
// concurrent checks on the ports of the hiccup and phase block
module hpc_top_properties
    import hpc_pkg::*;
(
    // clock, reset and bus handshake
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // pins
    input wire logic BIAS_ABOVE_3V3,
    input wire logic ENABLE_PIN,
    // outputs under watch
    input wire logic HIGH_SIDE_GATE_DRIVE,
    input wire logic LOW_SIDE_GATE_DRIVE,
    input wire logic SOFT_START_HOLD_LOW,
    input wire logic SOFT_START_ACTIVE,
    input wire logic ERROR_AMP_ENABLE,
    input wire logic COMPENSATION_NODE_OE,
    input wire logic INTERNAL_COMP_ALLOWED,
    input wire logic FREQUENCY_SET_RESISTOR_SLOPE,
    input wire logic SPREAD_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hs_low_cnt;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // cycles since the high-side drive was last on, saturating
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hs_low_cnt <= 8'hff;
        end else if (HIGH_SIDE_GATE_DRIVE) begin
            hs_low_cnt <= 8'h00;
        end else if (hs_low_cnt != 8'hff) begin
            hs_low_cnt <= hs_low_cnt + 8'h01;
        end
    end
    a_gates_apart: assert property (!(HIGH_SIDE_GATE_DRIVE && LOW_SIDE_GATE_DRIVE))
        else $error("both gate drives on");
    a_hs_after_ls: assert property ($rose(HIGH_SIDE_GATE_DRIVE) |->
        !$past(LOW_SIDE_GATE_DRIVE, 2)) else $error("high side on too soon after low side");
    a_ls_dead_time: assert property ($rose(LOW_SIDE_GATE_DRIVE) |->
        hs_low_cnt >= DEAD_CYC + 1) else $error("low side on without dead time");
    a_off_no_gates: assert property (SOFT_START_HOLD_LOW [*3] |->
        !HIGH_SIDE_GATE_DRIVE && !LOW_SIDE_GATE_DRIVE) else $error("gates on while held off");
    a_amp_released: assert property (ERROR_AMP_ENABLE == COMPENSATION_NODE_OE &&
        !(FREQUENCY_SET_RESISTOR_SLOPE && ERROR_AMP_ENABLE)) else $error("amplifier state wrong");
    a_no_int_comp: assert property (FREQUENCY_SET_RESISTOR_SLOPE |->
        !INTERNAL_COMP_ALLOWED && !SPREAD_ACTIVE) else $error("secondary with comp or spread");
    a_strap_held: assert property (BIAS_ABOVE_3V3 [*8] |-> $stable({SPREAD_ACTIVE,
        INTERNAL_COMP_ALLOWED, FREQUENCY_SET_RESISTOR_SLOPE, ERROR_AMP_ENABLE}))
        else $error("latched configuration changed");
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge longer than one cycle");
    a_disable_holds: assert property (!ENABLE_PIN [*6] |-> SOFT_START_HOLD_LOW)
        else $error("soft start not held while disabled");
    a_restart_ramp: assert property ($fell(SOFT_START_HOLD_LOW) |-> SOFT_START_ACTIVE)
        else $error("release without soft start");
endmodule

bind hpc_top hpc_top_properties u_props (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .BIAS_ABOVE_3V3(BIAS_ABOVE_3V3), .ENABLE_PIN(ENABLE_PIN),
    .HIGH_SIDE_GATE_DRIVE(HIGH_SIDE_GATE_DRIVE), .LOW_SIDE_GATE_DRIVE(LOW_SIDE_GATE_DRIVE),
    .SOFT_START_HOLD_LOW(SOFT_START_HOLD_LOW), .SOFT_START_ACTIVE(SOFT_START_ACTIVE),
    .ERROR_AMP_ENABLE(ERROR_AMP_ENABLE), .COMPENSATION_NODE_OE(COMPENSATION_NODE_OE),
    .INTERNAL_COMP_ALLOWED(INTERNAL_COMP_ALLOWED),
    .FREQUENCY_SET_RESISTOR_SLOPE(FREQUENCY_SET_RESISTOR_SLOPE), .SPREAD_ACTIVE(SPREAD_ACTIVE)
);

// ===== tb/hpc_top_test.sv
// self-checking bench for the hiccup and phase block
module hpc_top_test
    import hpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 99000;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat = 32'h0, dat_o;
    logic bias = 1'b1, trip = 1'b0, fb = 1'b1, en = 1'b1, light = 1'b0, skip = 1'b0;
    logic light_lvl = 1'b0;
    logic slow = 1'b0, sync_on = 1'b0, pwm_end, hs_below, ls_below, hs, ls, pg, hold, ss_act;
    logic amp, int_comp, slope, spread;
    logic [2:0] strap = STRAP_29K9;
    logic [2:0] codes [5] = '{STRAP_29K9, STRAP_41K2, STRAP_71K5, STRAP_90K9, STRAP_54K9};
    logic [7:0] cfg_exp [5] = '{8'h1c, 8'h5d, 8'hd9, 8'hb2, 8'h98};
    int mismatches = 0, checks_done = 0, cycles = 0, n, t0;

    hpc_top #(.SS_CYCLES(200)) u_hpc_top (
        .SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .BIAS_ABOVE_3V3(bias), .CONFIG_STRAP_PIN(strap), .CURRENT_LIMIT_TRIP(trip),
        .PWM_END(pwm_end), .FEEDBACK_SENSE_ABOVE_0V4(fb), .HIGH_SIDE_GATE_BELOW_2V(hs_below),
        .LOW_SIDE_GATE_BELOW_2V(ls_below), .ENABLE_PIN(en), .LIGHT_LOAD_OR_SYNC_INPUT(light),
        .PULSE_SKIP(skip), .HIGH_SIDE_GATE_DRIVE(hs), .LOW_SIDE_GATE_DRIVE(ls),
        .POWER_GOOD_OR_SYNC_OUTPUT(pg), .SOFT_START_HOLD_LOW(hold), .SOFT_START_ACTIVE(ss_act),
        .ERROR_AMP_ENABLE(amp), .COMPENSATION_NODE_OE(), .INTERNAL_COMP_ALLOWED(int_comp),
        .FREQUENCY_SET_RESISTOR_SLOPE(slope), .SPREAD_ACTIVE(spread));
    hpc_fet_model u_hpc_fet_model (.clk(clk), .slow(slow), .hs_drive(hs), .ls_drive(ls),
        .hs_below_2v(hs_below), .ls_below_2v(ls_below), .pwm_end(pwm_end));

    // 200 mhz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    // run length guard and external sync clock of 100 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (!sync_on) begin
            light <= light_lvl;
        end else if (cycles % 50 == 0) begin
            light <= ~light;
        end
        if (cycles == LIMIT) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic bus cycle, read data left in rdat; only the run guard ends the wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_run();
        rdat = 32'h0;
        for (int i = 0; i < 200 && rdat[1:0] !== 2'h2; i++) wb(1'b0, REG_STATUS, 32'h0);
    endtask
    // sync output highs and rises, high-side pulses over 800 cycles
    task automatic measure(input int e_hi, input int e_rise, input int e_hs);
        int hi, rise, hsr;
        logic pg_d, hs_d;
        hi = 0;
        rise = 0;
        hsr = 0;
        pg_d = pg;
        hs_d = hs;
        repeat (800) begin
            @(posedge clk);
            hi += pg;
            rise += pg && !pg_d;
            hsr += hs && !hs_d;
            pg_d = pg;
            hs_d = hs;
        end
        chk("sync_high", e_hi, hi);
        chk("sync_rise", e_rise, rise);
        chk("hs_pulses", e_hs, hsr);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_reset", {16'h0, PERIOD_RST}, rdat);
        wb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, rdat);
        foreach (codes[i]) begin
            bias <= 1'b0;
            repeat (4) @(posedge clk);
            strap <= codes[i];
            bias <= 1'b1;
            repeat (8) @(posedge clk);
            strap <= 3'h7;
            repeat (4) @(posedge clk);
            wb(1'b0, REG_STATUS, 32'h0);
            chk("config", cfg_exp[i], {rdat[7:4], amp, int_comp, slope, spread});
        end
        wait_run();
        measure(400, 2, 2);
        slow <= 1'b1;
        measure(400, 2, 2);
        light_lvl <= 1'b1;
        skip <= 1'b1;
        // the level rise looks like one sync edge until two periods pass
        repeat (850) @(posedge clk);
        measure(0, 0, 0);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("pfm_flag", 32'h1, rdat[ST_PFM]);
        skip <= 1'b0;
        light_lvl <= 1'b0;
        @(posedge clk);
        sync_on <= 1'b1;
        repeat (60) @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("lock_early", 32'h0, rdat[ST_LOCKED]);
        repeat (400) @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("lock_late", 32'h1, rdat[ST_LOCKED]);
        sync_on <= 1'b0;
        @(posedge clk);
        light_lvl <= 1'b0;
        en <= 1'b0;
        repeat (10) @(posedge clk);
        chk("shed_hold", 32'h1, hold);
        en <= 1'b1;
        repeat (6) @(posedge clk);
        chk("reenable_ss", 32'h1, ss_act);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b1, REG_CTRL, 32'h5);
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_rw", 32'h5, rdat);
        wb(1'b0, REG_COUNT, 32'h0);
        chk("count_reset", 32'h0, rdat);
        wait_run();
        trip <= 1'b1;
        repeat (12) @(posedge clk);
        wb(1'b0, REG_COUNT, 32'h0);
        chk("ovl_live", 32'h1, rdat[9:0] != 10'h0);
        trip <= 1'b0;
        repeat (40) @(posedge clk);
        wb(1'b0, REG_COUNT, 32'h0);
        chk("ovl_clear", 32'h0, rdat[9:0]);
        trip <= 1'b1;
        n = 0;
        while (hold !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        chk("ovl_time", 32'h1, n >= 2550 && n <= 2580);
        repeat (3) @(posedge clk);
        chk("off_gates", 32'h0, {hs, ls});
        fb <= 1'b0;
        n = 0;
        while (hold !== 1'b0 && n < 90000) begin
            @(posedge clk);
            n++;
        end
        t0 = cycles;
        chk("off_time", 32'h1, n >= 81910 && n <= 81935);
        chk("restart_ss", 32'h1, ss_act);
        repeat (20) @(posedge clk);
        wb(1'b0, REG_COUNT, 32'h0);
        chk("ss_no_count", 32'h0, rdat[9:0]);
        n = 0;
        while (ss_act !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk("ss_time", 32'h1, cycles - t0 >= 198 && cycles - t0 <= 203);
        trip <= 1'b0;
        wrap_up();
    end
endmodule
